// File: verilog/twm_pkg.sv
// Shared constants and types for the 16-bit timer waveform block
package twm_pkg;
  localparam int CNT_W = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h81;
  localparam logic [7:0] ADDR_CNT_L  = 8'h84;
  localparam logic [7:0] ADDR_CNT_H  = 8'h85;
  localparam logic [7:0] ADDR_CAP_L  = 8'h86;
  localparam logic [7:0] ADDR_CAP_H  = 8'h87;
  localparam logic [7:0] ADDR_CMPA_L = 8'h88;
  localparam logic [7:0] ADDR_CMPA_H = 8'h89;
  localparam logic [7:0] ADDR_CMPB_L = 8'h8A;
  localparam logic [7:0] ADDR_CMPB_H = 8'h8B;
  localparam logic [7:0] ADDR_STATUS = 8'h8C;
  localparam logic [7:0] ADDR_MASK   = 8'h8D;

  // Field positions and reset values
  localparam int CHA_HI = 7;
  localparam int CHA_LO = 6;
  localparam int CHB_HI = 5;
  localparam int CHB_LO = 4;
  localparam int MODE_LOW_HI = 1;
  localparam int MODE_LOW_LO = 0;
  localparam int CTRL_B_MODE_LO = 3;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_A_RST   = 8'h00;
  localparam int ST_OVF = 0;
  localparam int ST_MA  = 1;
  localparam int ST_MB  = 2;
  localparam int ST_W   = 3;

  // Counter landmarks
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8  = 16'h00FF;
  localparam logic [15:0] TOP_9  = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;

  // Waveform modes
  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_PC8      = 4'h1;
  localparam logic [3:0] MODE_PC9      = 4'h2;
  localparam logic [3:0] MODE_PC10     = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP  = 4'h4;
  localparam logic [3:0] MODE_FAST8    = 4'h5;
  localparam logic [3:0] MODE_FAST9    = 4'h6;
  localparam logic [3:0] MODE_FAST10   = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP  = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP  = 4'h9;
  localparam logic [3:0] MODE_PC_CAP   = 4'hA;
  localparam logic [3:0] MODE_PC_CMP   = 4'hB;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0] MODE_RESV     = 4'hD;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMP = 4'hF;

  // Compare-output action codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} twm_dir_e;
  typedef enum logic [1:0] {KIND_NONPWM = 2'h0, KIND_FAST = 2'h1, KIND_DUAL = 2'h3} twm_kind_e;
  typedef enum logic [1:0] {UPD_NOW = 2'h0, UPD_TOP = 2'h1, UPD_BOT = 2'h3} twm_upd_e;
endpackage

// File: verilog/twm_chan.sv
// Compare-output waveform unit for one timer channel
`timescale 1ns/1ps
`default_nettype none
module twm_chan (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire twm_pkg::twm_kind_e kind,
  input  wire logic [1:0]        code,
  input  wire logic              toggle_ok,
  input  wire logic              match,
  input  wire twm_pkg::twm_dir_e  dir,
  input  wire logic              top_hit,
  input  wire logic              port_data,
  input  wire logic              port_dir,
  output logic                   pin_out,
  output logic                   pin_oe
);
  typedef struct packed {
    logic wave;
  } twm_chan_s;

  twm_chan_s st_ff;
  twm_chan_s nxt_st;
  logic      connected;

  always_comb begin
    nxt_st = st_ff;
    unique case (kind)
      twm_pkg::KIND_NONPWM: begin
        if (match) begin
          unique case (code)
            twm_pkg::COM_OFF:    nxt_st.wave = st_ff.wave;
            twm_pkg::COM_TOGGLE: nxt_st.wave = ~st_ff.wave;
            twm_pkg::COM_CLEAR:  nxt_st.wave = 1'b0;
            twm_pkg::COM_SET:    nxt_st.wave = 1'b1;
          endcase
        end
      end
      twm_pkg::KIND_FAST: begin
        // With clear/set codes, wrap to BOTTOM outranks a match at TOP, so that match is dropped
        if (code[1] && top_hit) begin
          nxt_st.wave = ~code[0];
        end else if (code[1] && match) begin
          nxt_st.wave = code[0];
        end else if (code == twm_pkg::COM_TOGGLE && toggle_ok && match) begin
          nxt_st.wave = ~st_ff.wave;
        end
      end
      twm_pkg::KIND_DUAL: begin
        if (match && code[1]) begin
          nxt_st.wave = code[0] ^ (dir == twm_pkg::DIR_DOWN);
        end else if (match && code == twm_pkg::COM_TOGGLE && toggle_ok) begin
          nxt_st.wave = ~st_ff.wave;
        end
      end
      default: nxt_st = st_ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // In PWM modes a toggle code without the toggle privilege leaves the pin to the port
  assign connected = (code != twm_pkg::COM_OFF) &&
                     !(kind != twm_pkg::KIND_NONPWM && code == twm_pkg::COM_TOGGLE && !toggle_ok);
  assign pin_out = connected ? st_ff.wave : port_data;
  assign pin_oe  = port_dir;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_nonpwm_clear: assert property (kind == twm_pkg::KIND_NONPWM && match && code == twm_pkg::COM_CLEAR
    |=> !st_ff.wave) else $error("clear on match failed");
  a_fast_bottom: assert property (kind == twm_pkg::KIND_FAST && top_hit && code == twm_pkg::COM_CLEAR
    |=> st_ff.wave) else $error("set at bottom failed");
  a_dual_slope: assert property (kind == twm_pkg::KIND_DUAL && match && code == twm_pkg::COM_SET
    |=> st_ff.wave == ($past(dir) == twm_pkg::DIR_UP)) else $error("dual slope action wrong");
  a_toggle_gate: assert property (kind != twm_pkg::KIND_NONPWM && code == twm_pkg::COM_TOGGLE && !toggle_ok
    |=> $stable(st_ff.wave)) else $error("disallowed toggle");
endmodule
`default_nettype wire

// File: verilog/twm_timer.sv
// Timer counter, waveform mode decode, registers and interrupt
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module twm_timer #(
  parameter int CNT_W = twm_pkg::CNT_W
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       timer_clock_enable,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  input  wire logic       port_data_a,
  input  wire logic       port_dir_a,
  input  wire logic       port_data_b,
  input  wire logic       port_dir_b,
  output logic            chan_a_wave_out,
  output logic            chan_a_wave_oe,
  output logic            chan_b_wave_out,
  output logic            chan_b_wave_oe
);
  localparam int NCH = 2;

  if (CNT_W != twm_pkg::CNT_W) begin : g_chk
    $error("twm_timer only serves a 16-bit counter");
  end

  typedef struct packed {
    logic [7:0]                    ctrl_a;
    logic [1:0]                    mode_hi;
    logic [15:0]                   cnt;
    logic [15:0]                   cap;
    logic [15:0]                   cmpa_buf;
    logic [15:0]                   cmpb_buf;
    logic [15:0]                   cmpa;
    logic [15:0]                   cmpb;
    logic [7:0]                    tmp;
    twm_pkg::twm_dir_e             dir;
    logic [twm_pkg::ST_W-1:0]      status;
    logic [twm_pkg::ST_W-1:0]      mask;
    logic [7:0]                    rdata;
  } twm_state_s;

  twm_state_s         st_ff;
  twm_state_s         nxt_st;
  logic [3:0]         mode;
  twm_pkg::twm_kind_e kind;
  twm_pkg::twm_upd_e  upd;
  logic [15:0]        top;
  logic               tick;
  logic               top_hit;
  logic               bot_hit;
  logic               ovf_ev;
  logic               upd_ev;
  logic [15:0]        wv;
  logic [NCH-1:0]     match;
  logic [NCH-1:0]     port_data;
  logic [NCH-1:0]     port_dir;
  logic [NCH-1:0]     pin_out;
  logic [NCH-1:0]     pin_oe;
  logic [1:0]         code [NCH];
  logic [NCH-1:0]     toggle_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  assign tick = timer_clock_enable;
  assign mode = {st_ff.mode_hi, st_ff.ctrl_a[twm_pkg::MODE_LOW_HI:twm_pkg::MODE_LOW_LO]};

  always_comb begin
    kind = twm_pkg::KIND_NONPWM;
    upd  = twm_pkg::UPD_NOW;
    top  = twm_pkg::MAX;
    unique case (mode)
      twm_pkg::MODE_NORMAL, twm_pkg::MODE_RESV: top = twm_pkg::MAX;
      twm_pkg::MODE_CTC_CMP: top = st_ff.cmpa;
      twm_pkg::MODE_CTC_CAP: top = st_ff.cap;
      twm_pkg::MODE_PC8, twm_pkg::MODE_PC9, twm_pkg::MODE_PC10: begin
        kind = twm_pkg::KIND_DUAL;
        upd  = twm_pkg::UPD_TOP;
        top  = (mode == twm_pkg::MODE_PC8) ? twm_pkg::TOP_8 :
               (mode == twm_pkg::MODE_PC9) ? twm_pkg::TOP_9 : twm_pkg::TOP_10;
      end
      twm_pkg::MODE_PC_CAP, twm_pkg::MODE_PC_CMP: begin
        kind = twm_pkg::KIND_DUAL;
        upd  = twm_pkg::UPD_TOP;
        top  = (mode == twm_pkg::MODE_PC_CAP) ? st_ff.cap : st_ff.cmpa;
      end
      twm_pkg::MODE_PFC_CAP, twm_pkg::MODE_PFC_CMP: begin
        kind = twm_pkg::KIND_DUAL;
        upd  = twm_pkg::UPD_BOT;
        top  = (mode == twm_pkg::MODE_PFC_CAP) ? st_ff.cap : st_ff.cmpa;
      end
      twm_pkg::MODE_FAST8, twm_pkg::MODE_FAST9, twm_pkg::MODE_FAST10: begin
        kind = twm_pkg::KIND_FAST;
        upd  = twm_pkg::UPD_BOT;
        top  = (mode == twm_pkg::MODE_FAST8) ? twm_pkg::TOP_8 :
               (mode == twm_pkg::MODE_FAST9) ? twm_pkg::TOP_9 : twm_pkg::TOP_10;
      end
      twm_pkg::MODE_FAST_CAP, twm_pkg::MODE_FAST_CMP: begin
        kind = twm_pkg::KIND_FAST;
        upd  = twm_pkg::UPD_BOT;
        top  = (mode == twm_pkg::MODE_FAST_CAP) ? st_ff.cap : st_ff.cmpa;
      end
    endcase
  end

  assign top_hit = tick && (st_ff.cnt == top);
  assign bot_hit = tick && (st_ff.cnt == twm_pkg::BOTTOM);
  assign upd_ev  = (upd == twm_pkg::UPD_TOP) ? top_hit :
                   (upd == twm_pkg::UPD_BOT) ? bot_hit : 1'b0;
  // Overflow point follows the waveform kind
  assign ovf_ev  = (kind == twm_pkg::KIND_NONPWM) ? tick && (st_ff.cnt == twm_pkg::MAX) :
                   (kind == twm_pkg::KIND_FAST)   ? top_hit : bot_hit;
  assign match[0] = tick && (st_ff.cnt == st_ff.cmpa);
  assign match[1] = tick && (st_ff.cnt == st_ff.cmpb);
  assign wv = {st_ff.tmp, reg_wdata};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    // Counter step
    if (tick) begin
      if (kind != twm_pkg::KIND_DUAL) begin
        nxt_st.cnt = (st_ff.cnt == top) ? twm_pkg::BOTTOM : 16'(st_ff.cnt + 16'h0001);
      end else if (st_ff.dir == twm_pkg::DIR_UP) begin
        if (st_ff.cnt == top) begin
          nxt_st.dir = twm_pkg::DIR_DOWN;
          nxt_st.cnt = 16'(st_ff.cnt - 16'h0001);
        end else begin
          nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
        end
      end else begin
        if (st_ff.cnt == twm_pkg::BOTTOM) begin
          nxt_st.dir = twm_pkg::DIR_UP;
          nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
        end else begin
          nxt_st.cnt = 16'(st_ff.cnt - 16'h0001);
        end
      end
    end
    if (kind != twm_pkg::KIND_DUAL) begin
      nxt_st.dir = twm_pkg::DIR_UP;
    end
    // Buffered compare reload at the mode's update point
    if (upd_ev) begin
      nxt_st.cmpa = st_ff.cmpa_buf;
      nxt_st.cmpb = st_ff.cmpb_buf;
    end
    // Register writes; high byte parks in tmp until the low byte lands
    if (reg_wr) begin
      unique case (reg_addr)
        twm_pkg::ADDR_CTRL_A: nxt_st.ctrl_a = reg_wdata & twm_pkg::CTRL_A_WMASK;
        twm_pkg::ADDR_CTRL_B: nxt_st.mode_hi = reg_wdata[twm_pkg::CTRL_B_MODE_LO +: 2];
        twm_pkg::ADDR_CNT_H, twm_pkg::ADDR_CAP_H,
        twm_pkg::ADDR_CMPA_H, twm_pkg::ADDR_CMPB_H: nxt_st.tmp = reg_wdata;
        twm_pkg::ADDR_CNT_L:  nxt_st.cnt = wv;
        twm_pkg::ADDR_CAP_L:  nxt_st.cap = wv;
        twm_pkg::ADDR_CMPA_L: nxt_st.cmpa_buf = wv;
        twm_pkg::ADDR_CMPB_L: nxt_st.cmpb_buf = wv;
        twm_pkg::ADDR_MASK:   nxt_st.mask = reg_wdata[twm_pkg::ST_W-1:0];
        default: nxt_st.tmp = st_ff.tmp;
      endcase
    end
    // Immediate modes see the buffer at once
    if (upd == twm_pkg::UPD_NOW) begin
      nxt_st.cmpa = nxt_st.cmpa_buf;
      nxt_st.cmpb = nxt_st.cmpb_buf;
    end
    // Sticky flags: write one clears, a same-cycle event wins
    if (reg_wr && reg_addr == twm_pkg::ADDR_STATUS) begin
      nxt_st.status = st_ff.status & ~reg_wdata[twm_pkg::ST_W-1:0];
    end
    nxt_st.status[twm_pkg::ST_OVF] = nxt_st.status[twm_pkg::ST_OVF] | ovf_ev;
    nxt_st.status[twm_pkg::ST_MA]  = nxt_st.status[twm_pkg::ST_MA] | match[0];
    nxt_st.status[twm_pkg::ST_MB]  = nxt_st.status[twm_pkg::ST_MB] | match[1];
    // Read data valid in the cycle after the strobe only
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        twm_pkg::ADDR_CTRL_A: nxt_st.rdata = st_ff.ctrl_a;
        twm_pkg::ADDR_CTRL_B: nxt_st.rdata = 8'(st_ff.mode_hi) << twm_pkg::CTRL_B_MODE_LO;
        twm_pkg::ADDR_CNT_L:  nxt_st.rdata = st_ff.cnt[7:0];
        twm_pkg::ADDR_CNT_H:  nxt_st.rdata = st_ff.cnt[15:8];
        twm_pkg::ADDR_CAP_L:  nxt_st.rdata = st_ff.cap[7:0];
        twm_pkg::ADDR_CAP_H:  nxt_st.rdata = st_ff.cap[15:8];
        twm_pkg::ADDR_CMPA_L: nxt_st.rdata = st_ff.cmpa_buf[7:0];
        twm_pkg::ADDR_CMPA_H: nxt_st.rdata = st_ff.cmpa_buf[15:8];
        twm_pkg::ADDR_CMPB_L: nxt_st.rdata = st_ff.cmpb_buf[7:0];
        twm_pkg::ADDR_CMPB_H: nxt_st.rdata = st_ff.cmpb_buf[15:8];
        twm_pkg::ADDR_STATUS: nxt_st.rdata = 8'(st_ff.status);
        twm_pkg::ADDR_MASK:   nxt_st.rdata = 8'(st_ff.mask);
        default:              nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ctrl_a <= twm_pkg::CTRL_A_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign irq = |(st_ff.status & st_ff.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Output channels

  assign code[0] = st_ff.ctrl_a[twm_pkg::CHA_HI:twm_pkg::CHA_LO];
  assign code[1] = st_ff.ctrl_a[twm_pkg::CHB_HI:twm_pkg::CHB_LO];
  // Toggle is a channel A privilege in the compare-A TOP PWM modes and in fast PWM with capture TOP only
  assign toggle_ok[0] = (kind == twm_pkg::KIND_FAST) ?
                        (mode == twm_pkg::MODE_FAST_CAP || mode == twm_pkg::MODE_FAST_CMP) :
                        (mode == twm_pkg::MODE_PFC_CMP || mode == twm_pkg::MODE_PC_CMP);
  assign toggle_ok[1] = 1'b0;
  assign port_data = {port_data_b, port_data_a};
  assign port_dir  = {port_dir_b, port_dir_a};

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    twm_chan u_chan (
      .clk       (clk),
      .rst       (rst),
      .kind      (kind),
      .code      (code[i]),
      .toggle_ok (toggle_ok[i]),
      .match     (match[i]),
      .dir       (st_ff.dir),
      .top_hit   (top_hit),
      .port_data (port_data[i]),
      .port_dir  (port_dir[i]),
      .pin_out   (pin_out[i]),
      .pin_oe    (pin_oe[i])
    );
  end

  assign chan_a_wave_out = pin_out[0];
  assign chan_a_wave_oe  = pin_oe[0];
  assign chan_b_wave_out = pin_out[1];
  assign chan_b_wave_oe  = pin_oe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    !(reg_wr && reg_addr == twm_pkg::ADDR_CNT_L);
  endsequence

  sequence s_fast_wrap;
    tick && kind == twm_pkg::KIND_FAST && st_ff.cnt == top;
  endsequence

  a_tick_gates_cnt: assert property (!tick and s_quiet |=> $stable(st_ff.cnt))
    else $error("counter moved without timer tick");
  a_match_flag_a: assert property (tick && st_ff.cnt == st_ff.cmpa |=> st_ff.status[twm_pkg::ST_MA])
    else $error("compare A flag not set");
  a_ovf_at_max: assert property (tick && kind == twm_pkg::KIND_NONPWM && st_ff.cnt == twm_pkg::MAX
    |=> st_ff.status[twm_pkg::ST_OVF]) else $error("overflow at MAX missed");
  a_fast_wrap: assert property (s_fast_wrap and s_quiet |=> st_ff.cnt == twm_pkg::BOTTOM
    && st_ff.status[twm_pkg::ST_OVF]) else $error("fast wrap wrong");
  a_dual_turn: assert property (tick && kind == twm_pkg::KIND_DUAL && st_ff.dir == twm_pkg::DIR_UP
    && st_ff.cnt == top && top != twm_pkg::BOTTOM ##0 s_quiet |=> st_ff.dir == twm_pkg::DIR_DOWN)
    else $error("dual slope did not turn at TOP");
  a_dual_ovf: assert property (tick && kind == twm_pkg::KIND_DUAL && st_ff.cnt == twm_pkg::BOTTOM
    |=> st_ff.status[twm_pkg::ST_OVF]) else $error("overflow at BOTTOM missed");
  a_ctrl_a_resv: assert property (reg_wr && reg_addr == twm_pkg::ADDR_CTRL_A ##1 reg_rd
    && reg_addr == twm_pkg::ADDR_CTRL_A |=> reg_rdata[3:2] == 2'h0) else $error("reserved bits read set");
  a_pin_oe_dir: assert property (!port_dir_a |-> !chan_a_wave_oe)
    else $error("pin driven with direction clear");
  a_pin_route: assert property (code[0] == twm_pkg::COM_CLEAR || code[0] == twm_pkg::COM_SET
    |-> chan_a_wave_out == g_ch[0].u_chan.st_ff.wave) else $error("waveform not routed to pin");
  a_imm_update: assert property (upd == twm_pkg::UPD_NOW && reg_wr && reg_addr == twm_pkg::ADDR_CMPA_L
    ##1 upd == twm_pkg::UPD_NOW |-> st_ff.cmpa == st_ff.cmpa_buf) else $error("immediate update missed");

  sequence s_wr_status;
    reg_wr && reg_addr == twm_pkg::ADDR_STATUS;
  endsequence

  // Channel B never gets the toggle privilege
  a_chan_b_off: assert property (kind != twm_pkg::KIND_NONPWM && code[1] == twm_pkg::COM_TOGGLE
    |-> chan_b_wave_out == port_data_b) else $error("channel B toggle not disconnected");

  a_match_flag_b: assert property (tick && st_ff.cnt == st_ff.cmpb |=> st_ff.status[twm_pkg::ST_MB])
    else $error("compare B flag not set");

  // Buffered modes move the active compare only at their update point
  a_upd_load: assert property (upd_ev && upd != twm_pkg::UPD_NOW |=> st_ff.cmpa == $past(st_ff.cmpa_buf))
    else $error("buffered reload wrong");

  a_cmp_held: assert property (upd != twm_pkg::UPD_NOW && !upd_ev |=> $stable(st_ff.cmpa))
    else $error("compare moved between update points");

  a_ctrl_a_write: assert property (reg_wr && reg_addr == twm_pkg::ADDR_CTRL_A
    |=> st_ff.ctrl_a == ($past(reg_wdata) & twm_pkg::CTRL_A_WMASK)) else $error("control A write wrong");

  a_single_dir: assert property (kind != twm_pkg::KIND_DUAL |=> st_ff.dir == twm_pkg::DIR_UP)
    else $error("single-slope count went down");

  a_dual_bounce: assert property (tick && kind == twm_pkg::KIND_DUAL && st_ff.dir == twm_pkg::DIR_DOWN
    && st_ff.cnt == twm_pkg::BOTTOM ##0 s_quiet |=> st_ff.dir == twm_pkg::DIR_UP && st_ff.cnt != twm_pkg::BOTTOM)
    else $error("dual slope did not turn at BOTTOM");

  // Clearing all flags with no tick leaves nothing behind
  a_status_w1c: assert property (s_wr_status ##0 (&reg_wdata[twm_pkg::ST_W-1:0]) && !tick
    |=> st_ff.status == '0) else $error("status clear failed");

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// File: testbench/twm_timer_tb.sv
// Self-checking testbench for the timer waveform block
`timescale 1ns/1ps
`default_nettype none
module twm_timer_tb;
  logic       clk;
  logic       rst;
  logic       tce;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq;
  logic       pda;
  logic       pdira;
  logic       pdb;
  logic       pdirb;
  logic       oa;
  logic       oea;
  logic       ob;
  logic       oeb;
  int         fails;
  int         checked;
  logic [7:0] got;

  twm_timer dut (
    .clk                (clk),
    .rst                (rst),
    .timer_clock_enable (tce),
    .reg_addr           (addr),
    .reg_wdata          (wdata),
    .reg_wr             (wr),
    .reg_rd             (rd),
    .reg_rdata          (rdata),
    .irq                (irq),
    .port_data_a        (pda),
    .port_dir_a         (pdira),
    .port_data_b        (pdb),
    .port_dir_b         (pdirb),
    .chan_a_wave_out    (oa),
    .chan_a_wave_oe     (oea),
    .chan_b_wave_out    (ob),
    .chan_b_wave_oe     (oeb)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask

  // High byte first: low byte write commits the pair
  task automatic w16(input logic [7:0] ahi, input logic [15:0] v);
    wreg(ahi, v[15:8]);
    wreg(ahi - 8'h01, v[7:0]);
  endtask

  // Exactly n enabled timer steps, ticks kept away from register writes
  task automatic ticks(input int n);
    @(posedge clk);
    tce <= 1'b1;
    repeat (n) @(posedge clk);
    tce <= 1'b0;
    #1;
  endtask

  task automatic wrap_up;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rreg(twm_pkg::ADDR_CTRL_A);
    chk(got, 8'h00);
    wreg(twm_pkg::ADDR_CTRL_A, 8'hFF);
    rreg(twm_pkg::ADDR_CTRL_A);
    chk(got, 8'hF3);
    wreg(twm_pkg::ADDR_CTRL_B, 8'h18);
    rreg(twm_pkg::ADDR_CTRL_B);
    chk(got, 8'h18);
    rreg(8'h90);
    chk(got, 8'h00);
    wreg(twm_pkg::ADDR_CTRL_B, 8'h00);
    wreg(twm_pkg::ADDR_CTRL_A, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_nonpwm;
    logic [1:0] code [4];
    logic       expv [4];
    code = '{2'h1, 2'h2, 2'h3, 2'h1};
    expv = '{1'b1, 1'b0, 1'b1, 1'b0};
    chk({7'h0, oa}, 8'h01);
    chk({7'h0, ob}, 8'h01);
    chk({7'h0, oeb}, 8'h01);
    w16(twm_pkg::ADDR_CMPA_H, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      w16(twm_pkg::ADDR_CNT_H, 16'h0000);
      wreg(twm_pkg::ADDR_CTRL_A, {code[i], 6'h00});
      ticks(10);
      chk({7'h0, oa}, {7'h0, expv[i]});
      chk({7'h0, oea}, 8'h00);
    end
    rreg(twm_pkg::ADDR_STATUS);
    chk(got, 8'h06);
    @(posedge clk);
    pdira <= 1'b1;
    #1;
    chk({7'h0, oea}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wreg(twm_pkg::ADDR_MASK, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wreg(twm_pkg::ADDR_STATUS, 8'h02);
    chk({7'h0, irq}, 8'h00);
    // Second tick lands on the match, clear of any post-write blanking
    w16(twm_pkg::ADDR_CNT_H, 16'h0004);
    ticks(2);
    chk({7'h0, irq}, 8'h01);
    rreg(twm_pkg::ADDR_STATUS);
    chk(got, 8'h06);
    wreg(twm_pkg::ADDR_STATUS, 8'h07);
    $display("test nonpwm done");
  endtask

  task automatic t_fast;
    w16(twm_pkg::ADDR_CMPA_H, 16'h0010);
    w16(twm_pkg::ADDR_CNT_H, 16'h00F0);
    wreg(twm_pkg::ADDR_CTRL_B, 8'h08);
    wreg(twm_pkg::ADDR_CTRL_A, 8'h81);
    wreg(twm_pkg::ADDR_STATUS, 8'h07);
    ticks(16);
    chk({7'h0, oa}, 8'h01);
    rreg(twm_pkg::ADDR_STATUS);
    chk(got, 8'h01);
    ticks(17);
    chk({7'h0, oa}, 8'h00);
    rreg(twm_pkg::ADDR_CNT_L);
    chk(got, 8'h11);
    $display("test fast done");
  endtask

  task automatic t_dual;
    wreg(twm_pkg::ADDR_CTRL_B, 8'h00);
    wreg(twm_pkg::ADDR_CTRL_A, 8'hC1);
    w16(twm_pkg::ADDR_CNT_H, 16'h000F);
    ticks(2);
    chk({7'h0, oa}, 8'h01);
    ticks(470);
    chk({7'h0, oa}, 8'h01);
    rreg(twm_pkg::ADDR_CNT_L);
    chk(got, 8'h17);
    ticks(10);
    chk({7'h0, oa}, 8'h00);
    $display("test dual done");
  endtask

  // Mode 14: channel A toggles, channel B stays with the port
  task automatic t_toggle;
    w16(twm_pkg::ADDR_CAP_H, 16'h0020);
    wreg(twm_pkg::ADDR_CTRL_A, 8'h52);
    wreg(twm_pkg::ADDR_CTRL_B, 8'h18);
    w16(twm_pkg::ADDR_CNT_H, 16'h0000);
    chk({7'h0, ob}, 8'h01);
    ticks(17);
    chk({7'h0, oa}, 8'h01);
    chk({7'h0, ob}, 8'h01);
    $display("test toggle done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run is about 700 cycles
  initial begin
    #40000;
    fails++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    tce = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pda = 1'b1;
    pdira = 1'b0;
    pdb = 1'b1;
    pdirb = 1'b1;
    fails = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_nonpwm();
    t_fast();
    t_dual();
    t_toggle();
    wrap_up();
  end
endmodule
`default_nettype wire
